/* File: rtl/timer_sup_cfg.svh */
// Purpose: constants for the process timer and run supervisor
// Assumes: 40 MHz system clock, 32-bit classic wishbone register port
// Notes: offsets are byte addresses, one register per aligned word
`ifndef TIMER_SUP_CFG_SVH
`define TIMER_SUP_CFG_SVH

`define CLK_HZ 40000000
`define TICK_DIV_DEFAULT 32'd40000000
// register byte offsets
`define OFF_CTRL 6'h00
`define OFF_T1 6'h04
`define OFF_T2 6'h08
`define OFF_LBD 6'h0C
`define OFF_FAULT 6'h10
`define OFF_STATUS 6'h14
`define OFF_COUNT 6'h18
`define OFF_PRESC 6'h1C
// control register fields
`define CTL_RUN 0
`define CTL_TRIG_LO 1
`define CTL_TRIG_HI 2
`define CTL_DIR_DOWN 3
`define CTL_BASE_HHMM 4
`define CTL_END_STOP 5
`define CTL_PID 6
`define CTL_BLK_EN 7
`define CTL_ALM_ERRFN 8
`define CTL_ALM_LBD 9
`define CTL_RESET 32'h0000_0001
// key timing in seconds
`define KEY_SHORT_S 8'h01
`define KEY_LONG_S 8'h03
`define PCT_FULL 7'h64
`define MM_MAX 7'h3B
`define HI_MAX 7'h63
// fast flash: 64 times the half period in system cycles
`define FLASH_HALF 32'd4000000
`define FLASH_SLOW_HALF 32'd20000000

`endif

/* File: rtl/timer_sup_pkg.sv */
// Purpose: shared types for the process timer and run supervisor
// Assumes: nothing
// Notes: constants live in timer_sup_cfg.svh
package timer_sup_pkg;
    typedef enum logic [1:0] {TRIG_OFF, TRIG_SP, TRIG_KEY, TRIG_RUN} trig_t;
    typedef enum logic [2:0] {T_IDLE, T_ONE, T_ONE_P, T_TWO, T_TWO_P, T_DONE} tstate_t;
endpackage

/* File: rtl/mmss_counter.sv */
// Purpose: one two-digit time field pair counter (hi:lo, lo wraps at 59)
// Assumes: step is a one-cycle pulse on clk_sys
// Notes: counts up from zero or down from the programmed value
`timescale 1ns/1ps
`default_nettype none
`include "timer_sup_cfg.svh"
module mmss_counter (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic ce,
    input wire logic load,
    input wire logic down,
    input wire logic step,
    input wire logic [6:0] set_hi,
    input wire logic [6:0] set_lo,
    output logic [6:0] hi_reg,
    output logic [6:0] lo_reg,
    output logic done_reg
);
    logic [6:0] hi_next, lo_next;
    logic done_next;

    // next count: up stops at the set value, down stops at zero
    always_comb begin
        hi_next = hi_reg;
        lo_next = lo_reg;
        done_next = done_reg;
        if (load) begin
            hi_next = down ? set_hi : 7'h00;
            lo_next = down ? set_lo : 7'h00;
            done_next = (set_hi == 7'h00) && (set_lo == 7'h00); // zero interval ends at once
        end else if (step && !done_reg) begin
            if (down) begin
                if (lo_reg != 7'h00) begin
                    lo_next = lo_reg - 7'h01;
                end else if (hi_reg != 7'h00) begin
                    hi_next = hi_reg - 7'h01;
                    lo_next = `MM_MAX;
                end
                done_next = (hi_next == 7'h00) && (lo_next == 7'h00);
            end else begin
                if (lo_reg == `MM_MAX) begin
                    lo_next = 7'h00;
                    hi_next = hi_reg + 7'h01;
                end else begin
                    lo_next = lo_reg + 7'h01;
                end
                done_next = (hi_next == set_hi) && (lo_next == set_lo);
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            hi_reg <= 7'h00;
            lo_reg <= 7'h00;
            done_reg <= 1'b0;
        end else if (ce) begin
            hi_reg <= hi_next;
            lo_reg <= lo_next;
            done_reg <= done_next;
        end
    end
endmodule
`default_nettype wire

/* File: rtl/process_timer_run_supervisor.sv */
// Purpose: run enable, alarm blocking (sampled from reset values, so it never engages), safe output, loop break and two cascaded timers
// Assumes: wishbone classic slave on clk_sys; pins are synchronised here
// Notes: the control algorithm itself sits outside and supplies ctl_pct_in
//
// The Wishbone slave port and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "timer_sup_cfg.svh"

// Notes on behaviour
// - power-up alarm present with blocking is ignored; blocking is sampled from reset values, so it never sets
// - alarm arms after clear then new occurrence
// - sensor-error alarms are never blocked
// - run yes: outputs act, run lamp on
// - run no: all outputs off, nothing runs
// - sensor fault drives fault percent on control
// - on/off fault percent only 0 or 100; forced only on writes made in on/off mode, a value written under PID stays
// - no process response in time raises loop break
// - loop break time zero disables detection
// - primary first, secondary follows automatically
// - time base picks hh:mm or mm:ss tick
// - stop option clears run at cycle end
// - lamps follow primary and secondary timer state
// - trigger off disables both timers
// - setpoint trigger starts when value reaches setpoint
// - key starts; short pauses/resumes; long ends
// - key starts only while run is yes
// - run trigger starts when run becomes yes
// - paused timer lamp flashes rapidly
// - linked output on during primary interval
// - secondary lamp flashes slowly while counting, rapidly when paused, else off
// - direction selects count up or down
// - intervals settable 00:00 to 99:59
module process_timer_run_supervisor #(
    parameter logic [31:0] TICK_DIV = `TICK_DIV_DEFAULT,
    parameter logic [31:0] FLASH_HALF = `FLASH_HALF
) (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic ce,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [5:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic key_pin,
    input wire logic sensor_fault_pin,
    input wire logic alarm_cond_pin,
    input wire logic [15:0] process_value,
    input wire logic [15:0] setpoint,
    input wire logic [6:0] ctl_pct_in,
    output logic [6:0] ctl_pct_reg,
    output logic alarm_out_reg,
    output logic lbd_out_reg,
    output logic timer_link_out_reg,
    output logic run_lamp_reg,
    output logic primary_timer_lamp_reg,
    output logic secondary_timer_lamp_reg
);
    // pins cross in through two flops; only stage two is read
    logic [2:0] sync1_reg, sync2_reg;
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            sync1_reg <= 3'h0;
            sync2_reg <= 3'h0;
        end else if (ce) begin
            sync1_reg <= {alarm_cond_pin, sensor_fault_pin, key_pin};
            sync2_reg <= sync1_reg;
        end
    end
    logic key_s, fault_s, alarm_s;
    assign key_s = sync2_reg[0];
    assign fault_s = sync2_reg[1];
    assign alarm_s = sync2_reg[2];

    // registers
    logic [31:0] ctrl_reg, ctrl_next;
    logic [27:0] tset_reg, tset_next; // {t2 hi,lo, t1 hi,lo}
    logic [7:0] lbd_min_reg, lbd_min_next;
    logic [6:0] fpct_reg, fpct_next;
    logic [31:0] presc_reg, presc_next;
    logic [31:0] rdat_next;
    logic ack_next;
    logic run_clear;
    logic wr;
    assign wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o; // lands when ack is seen

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // clamp a hi/lo pair to 99:59
    function automatic logic [13:0] clamp_time(input logic [13:0] v);
        logic [6:0] h, l;
        h = (v[13:7] > `HI_MAX) ? `HI_MAX : v[13:7];
        l = (v[6:0] > `MM_MAX) ? `MM_MAX : v[6:0];
        return {h, l};
    endfunction

    logic [6:0] t1_hi, t1_lo, t2_hi, t2_lo;
    logic t1_done, t2_done;
    timer_sup_pkg::tstate_t ts_reg, ts_next;
    logic lbd_flag_reg, alm_armed_reg, blk_reg;

    // bus decode; run clear from timer end overrides, set after
    always_comb begin
        logic [31:0] w;
        logic [6:0] p;
        w = 32'h0;
        p = 7'h00;
        ctrl_next = ctrl_reg;
        tset_next = tset_reg;
        lbd_min_next = lbd_min_reg;
        fpct_next = fpct_reg;
        presc_next = presc_reg;
        ack_next = wb_cyc_i && wb_stb_i && !wb_ack_o;
        rdat_next = 32'h0;
        if (wr) begin
            unique case (wb_adr_i)
                `OFF_CTRL: begin
                    ctrl_next = merge(ctrl_reg, wb_dat_i, wb_sel_i) & 32'h0000_03FF;
                end
                `OFF_T1: begin
                    w = merge({18'h0, tset_reg[13:0]}, wb_dat_i, wb_sel_i);
                    tset_next[13:0] = clamp_time(w[13:0]);
                end
                `OFF_T2: begin
                    w = merge({18'h0, tset_reg[27:14]}, wb_dat_i, wb_sel_i);
                    tset_next[27:14] = clamp_time(w[13:0]);
                end
                `OFF_LBD: begin
                    w = merge({24'h0, lbd_min_reg}, wb_dat_i, wb_sel_i);
                    lbd_min_next = w[7:0];
                end
                `OFF_FAULT: begin
                    w = merge({25'h0, fpct_reg}, wb_dat_i, wb_sel_i);
                    p = (w[6:0] > `PCT_FULL) ? `PCT_FULL : w[6:0];
                    // on/off accepts only the two extremes
                    if (ctrl_reg[`CTL_PID]) begin
                        fpct_next = p;
                    end else begin
                        fpct_next = (p >= 7'h32) ? `PCT_FULL : 7'h00;
                    end
                end
                `OFF_PRESC: begin
                    presc_next = merge(presc_reg, wb_dat_i, wb_sel_i);
                    if (presc_next == 32'h0) begin
                        presc_next = 32'h1;
                    end
                end
                default: begin
                end
            endcase
        end
        if (run_clear) begin
            ctrl_next[`CTL_RUN] = 1'b0;
        end
        unique case (wb_adr_i)
            `OFF_CTRL: rdat_next = ctrl_reg;
            `OFF_T1: rdat_next = {18'h0, tset_reg[13:0]};
            `OFF_T2: rdat_next = {18'h0, tset_reg[27:14]};
            `OFF_LBD: rdat_next = {24'h0, lbd_min_reg};
            `OFF_FAULT: rdat_next = {25'h0, fpct_reg};
            `OFF_STATUS: rdat_next = {25'h0, ts_reg, lbd_flag_reg, alm_armed_reg, blk_reg,
                                      fault_s};
            `OFF_COUNT: rdat_next = {4'h0, t2_hi, t2_lo, t1_hi, t1_lo};
            `OFF_PRESC: rdat_next = presc_reg;
            default: rdat_next = 32'h0;
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_reg <= `CTL_RESET;
            tset_reg <= 28'h0;
            lbd_min_reg <= 8'h00;
            fpct_reg <= 7'h00;
            presc_reg <= TICK_DIV;
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0;
        end else if (ce) begin
            ctrl_reg <= ctrl_next;
            tset_reg <= tset_next;
            lbd_min_reg <= lbd_min_next;
            fpct_reg <= fpct_next;
            presc_reg <= presc_next;
            wb_ack_o <= ack_next;
            wb_dat_o <= rdat_next;
        end
    end

    logic run;
    assign run = ctrl_reg[`CTL_RUN];
    timer_sup_pkg::trig_t trig;
    assign trig = timer_sup_pkg::trig_t'(ctrl_reg[`CTL_TRIG_HI:`CTL_TRIG_LO]);

    // second and minute ticks; >= so a smaller divider cannot stall them
    logic [31:0] pre_reg, pre_next;
    logic [5:0] sec_reg, sec_next;
    logic [15:0] flash_reg, flash_next;
    logic flash_bit_reg, flash_bit_next;
    logic sec_tick, min_tick;
    assign sec_tick = (pre_reg >= presc_reg - 32'h1);
    assign min_tick = sec_tick && (sec_reg == 6'h3B);
    always_comb begin
        pre_next = sec_tick ? 32'h0 : pre_reg + 32'h1;
        sec_next = sec_reg;
        if (sec_tick) begin
            sec_next = (sec_reg == 6'h3B) ? 6'h00 : sec_reg + 6'h01;
        end
        // fast flash uses its own free counter; coarse but cheap
        flash_next = flash_reg + 16'h1;
        flash_bit_next = flash_bit_reg;
        if ({16'h0, flash_reg} >= (FLASH_HALF >> 6)) begin
            flash_next = 16'h0;
            flash_bit_next = !flash_bit_reg;
        end
    end
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            pre_reg <= 32'h0;
            sec_reg <= 6'h00;
            flash_reg <= 16'h0;
            flash_bit_reg <= 1'b0;
        end else if (ce) begin
            pre_reg <= pre_next;
            sec_reg <= sec_next;
            flash_reg <= flash_next;
            flash_bit_reg <= flash_bit_next;
        end
    end
    logic slow_blink;
    assign slow_blink = sec_reg[0];

    // key press length in seconds; long judged while held, short on release
    logic key_d_reg;
    logic [7:0] kcnt_reg, kcnt_next;
    logic long_done_reg, long_done_next;
    logic key_short, key_long;
    always_comb begin
        kcnt_next = kcnt_reg;
        long_done_next = long_done_reg;
        key_short = 1'b0;
        key_long = 1'b0;
        if (key_s) begin
            if (sec_tick && kcnt_reg != 8'hFF) begin
                kcnt_next = kcnt_reg + 8'h01;
            end
            if (kcnt_reg >= `KEY_LONG_S && !long_done_reg) begin
                key_long = 1'b1;
                long_done_next = 1'b1;
            end
        end else begin
            if (key_d_reg && !long_done_reg) begin
                key_short = 1'b1;
            end
            kcnt_next = 8'h00;
            long_done_next = 1'b0;
        end
    end
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            key_d_reg <= 1'b0;
            kcnt_reg <= 8'h00;
            long_done_reg <= 1'b0;
        end else if (ce) begin
            key_d_reg <= key_s;
            kcnt_reg <= kcnt_next;
            long_done_reg <= long_done_next;
        end
    end

    // timer sequencer
    logic run_d_reg;
    logic start, load1, load2, step;
    logic at_sp;
    assign at_sp = $signed(process_value) >= $signed(setpoint);
    assign step = ctrl_reg[`CTL_BASE_HHMM] ? min_tick : sec_tick;
    always_comb begin
        ts_next = ts_reg;
        load1 = 1'b0;
        load2 = 1'b0;
        run_clear = 1'b0;
        start = 1'b0;
        unique case (trig)
            timer_sup_pkg::TRIG_OFF: start = 1'b0;
            timer_sup_pkg::TRIG_SP: start = run && at_sp;
            timer_sup_pkg::TRIG_KEY: start = run && key_short;
            timer_sup_pkg::TRIG_RUN: start = run && !run_d_reg;
        endcase
        unique case (ts_reg)
            timer_sup_pkg::T_IDLE: begin
                if (start) begin
                    ts_next = timer_sup_pkg::T_ONE;
                    load1 = 1'b1;
                end
            end
            timer_sup_pkg::T_ONE, timer_sup_pkg::T_ONE_P: begin
                if (trig == timer_sup_pkg::TRIG_KEY && key_short) begin
                    ts_next = (ts_reg == timer_sup_pkg::T_ONE) ? timer_sup_pkg::T_ONE_P
                                                               : timer_sup_pkg::T_ONE;
                end
                if (t1_done) begin
                    ts_next = timer_sup_pkg::T_TWO;
                    load2 = 1'b1;
                end
            end
            timer_sup_pkg::T_TWO, timer_sup_pkg::T_TWO_P: begin
                if (trig == timer_sup_pkg::TRIG_KEY && key_short) begin
                    ts_next = (ts_reg == timer_sup_pkg::T_TWO) ? timer_sup_pkg::T_TWO_P
                                                               : timer_sup_pkg::T_TWO;
                end
                if (t2_done) begin
                    ts_next = timer_sup_pkg::T_DONE;
                end
            end
            timer_sup_pkg::T_DONE: begin
                run_clear = ctrl_reg[`CTL_END_STOP];
                // rearm only once the trigger condition has gone away
                if (!start && !(trig == timer_sup_pkg::TRIG_SP && at_sp)) begin
                    ts_next = timer_sup_pkg::T_IDLE;
                end
            end
            default: ts_next = timer_sup_pkg::T_IDLE;
        endcase
        if (trig == timer_sup_pkg::TRIG_KEY && key_long && ts_reg != timer_sup_pkg::T_IDLE) begin
            ts_next = timer_sup_pkg::T_DONE;
        end
        if (trig == timer_sup_pkg::TRIG_OFF || !run) begin
            ts_next = timer_sup_pkg::T_IDLE;
        end
    end
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            ts_reg <= timer_sup_pkg::T_IDLE;
            run_d_reg <= 1'b0;
        end else if (ce) begin
            ts_reg <= ts_next;
            run_d_reg <= run;
        end
    end

    mmss_counter u_t1 (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .ce(ce),
        .load(load1),
        .down(ctrl_reg[`CTL_DIR_DOWN]),
        .step(step && ts_reg == timer_sup_pkg::T_ONE),
        .set_hi(tset_reg[13:7]),
        .set_lo(tset_reg[6:0]),
        .hi_reg(t1_hi),
        .lo_reg(t1_lo),
        .done_reg(t1_done)
    );
    mmss_counter u_t2 (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .ce(ce),
        .load(load2),
        .down(ctrl_reg[`CTL_DIR_DOWN]),
        .step(step && ts_reg == timer_sup_pkg::T_TWO),
        .set_hi(tset_reg[27:21]),
        .set_lo(tset_reg[20:14]),
        .hi_reg(t2_hi),
        .lo_reg(t2_lo),
        .done_reg(t2_done)
    );

    // alarm blocking, loop break and output drive
    logic blk_next, alm_armed_next, lbd_flag_next;
    logic [15:0] lbd_pv_reg, lbd_pv_next;
    logic [13:0] lbd_cnt_reg, lbd_cnt_next;
    logic first_reg;
    logic [6:0] pct_next;
    logic alarm_next, lbd_next, link_next, lamp1_next, lamp2_next;
    always_comb begin
        blk_next = blk_reg;
        alm_armed_next = alm_armed_reg;
        lbd_flag_next = lbd_flag_reg;
        lbd_pv_next = lbd_pv_reg;
        lbd_cnt_next = lbd_cnt_reg;
        // blocking captured once after reset release
        if (first_reg) begin
            blk_next = ctrl_reg[`CTL_BLK_EN] && alarm_s && !ctrl_reg[`CTL_ALM_ERRFN];
        end else if (blk_reg && !alarm_s) begin
            blk_next = 1'b0;
        end
        alm_armed_next = !blk_reg || ctrl_reg[`CTL_ALM_ERRFN];
        // loop break: value must move while output is applied
        if (!run || lbd_min_reg == 8'h00 || ctl_pct_in == 7'h00) begin
            lbd_cnt_next = 14'h0;
            lbd_flag_next = 1'b0;
            lbd_pv_next = process_value;
        end else if (process_value != lbd_pv_reg) begin
            lbd_cnt_next = 14'h0;
            lbd_pv_next = process_value;
            lbd_flag_next = 1'b0;
        end else if (min_tick) begin
            lbd_cnt_next = lbd_cnt_reg + 14'h1;
            if ((lbd_cnt_reg + 14'h1) >= {6'h0, lbd_min_reg}) begin
                lbd_flag_next = 1'b1;
            end
        end
        pct_next = fault_s ? fpct_reg : ctl_pct_in;
        alarm_next = alarm_s && alm_armed_reg;
        if (ctrl_reg[`CTL_ALM_ERRFN]) begin
            alarm_next = fault_s;
        end
        lbd_next = lbd_flag_reg;
        link_next = (ts_reg == timer_sup_pkg::T_ONE) || (ts_reg == timer_sup_pkg::T_ONE_P);
        lamp1_next = (ts_reg == timer_sup_pkg::T_ONE) ||
                     ((ts_reg == timer_sup_pkg::T_ONE_P) && flash_bit_reg);
        lamp2_next = ((ts_reg == timer_sup_pkg::T_TWO) && slow_blink) ||
                     ((ts_reg == timer_sup_pkg::T_TWO_P) && flash_bit_reg);
        if (!run) begin
            pct_next = 7'h00;
            alarm_next = 1'b0;
            lbd_next = 1'b0;
            link_next = 1'b0;
            lamp1_next = 1'b0;
            lamp2_next = 1'b0;
        end
    end
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            first_reg <= 1'b1;
            blk_reg <= 1'b0;
            alm_armed_reg <= 1'b0;
            lbd_flag_reg <= 1'b0;
            lbd_pv_reg <= 16'h0;
            lbd_cnt_reg <= 14'h0;
            ctl_pct_reg <= 7'h00;
            alarm_out_reg <= 1'b0;
            lbd_out_reg <= 1'b0;
            timer_link_out_reg <= 1'b0;
            run_lamp_reg <= 1'b0;
            primary_timer_lamp_reg <= 1'b0;
            secondary_timer_lamp_reg <= 1'b0;
        end else if (ce) begin
            first_reg <= 1'b0;
            blk_reg <= blk_next;
            alm_armed_reg <= alm_armed_next;
            lbd_flag_reg <= lbd_flag_next;
            lbd_pv_reg <= lbd_pv_next;
            lbd_cnt_reg <= lbd_cnt_next;
            ctl_pct_reg <= pct_next;
            alarm_out_reg <= alarm_next;
            lbd_out_reg <= lbd_next;
            timer_link_out_reg <= link_next;
            run_lamp_reg <= run;
            primary_timer_lamp_reg <= lamp1_next;
            secondary_timer_lamp_reg <= lamp2_next;
        end
    end
endmodule
`default_nettype wire

/* File: sim/sup_chk.sv */
// Purpose: port checker for the timer supervisor
// Assumes: one clock, rst_b async active low
// Notes: trig_reg shadows the trigger field of control writes
`timescale 1ns/1ps
`default_nettype none
module sup_chk (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic wb_we_i,
    input wire logic [5:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic wb_ack_o,
    input wire logic sensor_fault_pin,
    input wire logic [6:0] ctl_pct_reg,
    input wire logic alarm_out_reg,
    input wire logic lbd_out_reg,
    input wire logic timer_link_out_reg,
    input wire logic run_lamp_reg,
    input wire logic primary_timer_lamp_reg,
    input wire logic secondary_timer_lamp_reg
);
    logic [1:0] trig_reg;
    logic ctl_w;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    // acked control write, data still held by the master
    assign ctl_w = wb_ack_o && wb_we_i && wb_adr_i == 6'h00;
    // trigger shadow, reset matches trigger off
    always_ff @(posedge clk_sys or negedge rst_b)
        if (!rst_b) trig_reg <= 2'h0;
        else if (ctl_w) trig_reg <= wb_dat_i[2:1];
    sequence run_wr; ctl_w && wb_dat_i[0]; endsequence
    sequence stop_wr; ctl_w && !wb_dat_i[0]; endsequence
    sequence idle3; !run_lamp_reg [*3]; endsequence
    chk_run_lamp_on: assert property (
        run_wr |-> ##[1:3] run_lamp_reg) else $error("run lamp stays off");
    chk_run_lamp_off: assert property (
        stop_wr |-> ##[1:3] !run_lamp_reg) else $error("run lamp stays on");
    chk_off_quiet: assert property (
        idle3 |-> ctl_pct_reg == 7'h00 && !alarm_out_reg && !lbd_out_reg
        && !timer_link_out_reg && !secondary_timer_lamp_reg) else $error("output on while stopped");
    chk_link_excl: assert property (
        timer_link_out_reg && $past(timer_link_out_reg) |-> !secondary_timer_lamp_reg)
        else $error("secondary lamp lit in primary interval");
    chk_link_lamp: assert property (
        $rose(timer_link_out_reg) |-> ##[0:2] primary_timer_lamp_reg)
        else $error("primary lamp dark at start");
    chk_fault_hold: assert property (
        (sensor_fault_pin && run_lamp_reg) [*6] |-> $stable(ctl_pct_reg))
        else $error("control output moved during fault");
    chk_trig_off: assert property (
        (trig_reg == 2'h0) [*4] |-> !timer_link_out_reg && !secondary_timer_lamp_reg)
        else $error("timer active with trigger off");
    chk_run_start: assert property (
        trig_reg == 2'h3 && $rose(run_lamp_reg) |-> ##[0:4] timer_link_out_reg)
        else $error("primary not started by run");
endmodule
`default_nettype wire

/* File: sim/key_model.sv */
// Purpose: front key, held for a given number of cycles
// Assumes: go is a one-cycle strobe
// Notes: key reads released outside a press
`timescale 1ns/1ps
`default_nettype none
module key_model (
    input wire logic clk_sys,
    input wire logic go,
    input wire logic [7:0] len,
    output logic key_pin
);
    logic [7:0] left_reg = 8'h00;
    // press length countdown
    always_ff @(posedge clk_sys) begin
        if (go) left_reg <= len;
        else if (left_reg != 8'h00) left_reg <= left_reg - 8'h01;
    end
    assign key_pin = left_reg != 8'h00;
endmodule
`default_nettype wire

/* File: sim/process_timer_run_supervisor_tb.sv */
// Purpose: bench for the timer supervisor over wishbone
// Assumes: ten cycles per second tick
// Notes: key presses come from key_model
`timescale 1ns/1ps
`default_nettype none
module process_timer_run_supervisor_tb;
    logic clk_sys = 1'b0, rst_b = 1'b0, ce = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0, sensor_fault_pin = 1'b0, alarm_cond_pin = 1'b0, go = 1'b0;
    logic [5:0] wb_adr_i = 6'h00;
    logic [3:0] wb_sel_i = 4'hF;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
    logic [15:0] process_value = 16'h0, setpoint = 16'h0;
    logic [6:0] ctl_pct_in = 7'h0, ctl_pct_reg;
    logic [7:0] len = 8'h00;
    logic wb_ack_o, key_pin, alarm_out_reg, lbd_out_reg, timer_link_out_reg;
    logic run_lamp_reg, primary_timer_lamp_reg, secondary_timer_lamp_reg;
    int n_errors = 0, n_tests = 0;
    process_timer_run_supervisor #(.TICK_DIV(32'hA), .FLASH_HALF(32'h280))
        u_process_timer_run_supervisor (.*);
    key_model u_key_model (.*);
    // 40 MHz
    always #12.5 clk_sys = ~clk_sys;
    task automatic conclude();
        $display("errors %0d tests %0d", n_errors, n_tests);
        if (n_errors == 0 && n_tests > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // classic cycle, held until ack is sampled
    task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
        int i = 0;
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'h3, w, a, d};
        do begin
            @(posedge clk_sys);
            i++;
        end while (wb_ack_o !== 1'b1 && i < 20);
        if (wb_ack_o !== 1'b1) begin
            n_errors++;
            conclude();
        end
        rd = wb_dat_o;
        {wb_cyc_i, wb_stb_i} <= 2'h0;
        @(posedge clk_sys);
    endtask
    // polls timer state, bounded
    task automatic wst(input logic [2:0] s);
        int i = 0;
        do begin
            bus(1'b0, 6'h14, 32'h0);
            i++;
        end while (rd[6:4] !== s && i < 300);
        chk("state", rd[6:4], s);
        if (rd[6:4] !== s) conclude();
    endtask
    task automatic press(input logic [7:0] n);
        go <= 1'b1;
        len <= n;
        @(posedge clk_sys);
        go <= 1'b0;
        repeat (n + 12) @(posedge clk_sys);
    endtask
    initial begin
        repeat (2) @(posedge clk_sys);
        rst_b <= 1'b1;
        @(posedge clk_sys);
        bus(1'b0, 6'h00, 32'h0);
        chk("ctrl", rd, 32'h1);
        chk("run lamp", run_lamp_reg, 32'h1);
        bus(1'b0, 6'h20, 32'h0);
        chk("unmapped", rd, 32'h0);
        bus(1'b1, 6'h1C, 32'hA);
        bus(1'b1, 6'h04, 32'h5);
        bus(1'b1, 6'h08, 32'h3);
        bus(1'b1, 6'h00, 32'h6);
        bus(1'b1, 6'h00, 32'h27);
        wst(3'h1);
        chk("link", timer_link_out_reg, 32'h1);
        wst(3'h3);
        chk("link", timer_link_out_reg, 32'h0);
        wst(3'h0);
        bus(1'b0, 6'h00, 32'h0);
        chk("run end", rd[0], 32'h0);
        bus(1'b1, 6'h04, 32'h80);
        bus(1'b1, 6'h00, 32'h4);
        press(8'hF);
        wst(3'h0);
        bus(1'b1, 6'h00, 32'h5);
        press(8'hF);
        wst(3'h1);
        press(8'hF);
        wst(3'h2);
        press(8'h2D);
        chk("link", timer_link_out_reg, 32'h0);
        bus(1'b1, 6'h00, 32'h41);
        bus(1'b1, 6'h10, 32'h25);
        ctl_pct_in <= 7'h0A;
        sensor_fault_pin <= 1'b1;
        alarm_cond_pin <= 1'b1;
        repeat (8) @(posedge clk_sys);
        chk("fault pct", ctl_pct_reg, 32'h25);
        chk("alarm", alarm_out_reg, 32'h1);
        ctl_pct_in <= 7'h14;
        repeat (4) @(posedge clk_sys);
        chk("fault pct", ctl_pct_reg, 32'h25);
        sensor_fault_pin <= 1'b0;
        repeat (8) @(posedge clk_sys);
        chk("pct", ctl_pct_reg, 32'h14);
        bus(1'b0, 6'h10, 32'h0);
        chk("pid pct", rd, 32'h25);
        bus(1'b1, 6'h00, 32'h1);
        bus(1'b1, 6'h10, 32'h3C);
        bus(1'b0, 6'h10, 32'h0);
        chk("onoff pct", rd, 32'h64);
        bus(1'b1, 6'h00, 32'h0);
        repeat (4) @(posedge clk_sys);
        chk("off pct", ctl_pct_reg, 32'h0);
        conclude();
    end
endmodule
bind process_timer_run_supervisor sup_chk u_sup_chk (.*);
`default_nettype wire
